// ==== verilog/ptp_cfg.svh ====
// Purpose: offsets, field codes, reset values and segment counts of the timer block
// Assumes: word-indexed register port, 16-bit data
// Notes: definitions only
`ifndef PTP_CFG_SVH
`define PTP_CFG_SVH

// ************************************************************
// register indices
// ************************************************************
`define PTP_A_CTRL 5'h00
`define PTP_A_STATE 5'h01
`define PTP_A_PRISP 5'h02
`define PTP_A_ALTSP 5'h03
`define PTP_A_DUR 5'h04
`define PTP_A_BAND 5'h05
`define PTP_A_SSLIM 5'h06
`define PTP_A_SSREL 5'h07
`define PTP_A_DRATE 5'h08
`define PTP_A_ELAPSED 5'h09
`define PTP_A_WSP 5'h0A
// segment block: bit 4 set, pair in [3:2], field in [1:0]
`define PTP_SEG_BIT 4
`define PTP_F_TGT 2'h0
`define PTP_F_RATE 2'h1
`define PTP_F_DWELL 2'h2

// ************************************************************
// reset values
// ************************************************************
`define PTP_CTRL_W 9
`define PTP_CTRL_RST 9'h004
`define PTP_DATA_RST 16'h0000
`define PTP_LIMIT_FULL 16'hFFFF

// ************************************************************
// segment counts
// ************************************************************
`define PTP_PAIRS 4
`define PTP_LAST_SEG 4'h7
`define PTP_FINAL_SEG 4'h8

`endif

// ==== verilog/ptp_pkg.sv ====
// Purpose: types shared by the timer block
// Assumes: ptp_cfg.svh for widths
// Notes: enum codes are the software-visible encodings
`include "ptp_cfg.svh"
package ptp_pkg;
    // timer behaviour selector
    typedef enum logic [1:0] {
        MD_DWELL = 2'h0, MD_DELAY = 2'h1, MD_SOFT = 2'h2, MD_PROG = 2'h3
    } ptp_mode_e;
    // what the end state does
    typedef enum logic [1:0] {
        EA_OFF = 2'h0, EA_DWELL = 2'h1, EA_ALT = 2'h2, EA_RESET = 2'h3
    } ptp_end_e;
    // how a program starts and recovers
    typedef enum logic [1:0] {
        SV_SP = 2'h0, SV_PV = 2'h1, SV_SPRB = 2'h2, SV_PVRB = 2'h3
    } ptp_servo_e;
    // timer state, gray along reset-run-hold-end
    typedef enum logic [1:0] {
        ST_RESET = 2'h0, ST_RUN = 2'h1, ST_HOLD = 2'h3, ST_END = 2'h2
    } ptp_state_e;
    // control word layout, msb first
    typedef struct packed {
        logic spSel;
        logic rampEn;
        logic bandOff;
        ptp_servo_e servo;
        ptp_end_e endAct;
        ptp_mode_e mode;
    } ptp_ctrl_s;
endpackage

// ==== verilog/ptp_timer.sv ====
// Purpose: dwell, delay, soft start timer and 8-segment programmer
// Assumes: tick, commands and temperature are on the clock domain
// Notes: all durations count tick strobes
`timescale 1ns/1ps
`include "ptp_cfg.svh"

module ptp_timer #(
    parameter int DW = 16,
    parameter int AW = 5
) (
    // clock and reset
    input wire logic clock,
    input wire logic rst,
    // timebase and supply recovery
    input wire logic tick,
    input wire logic powerRestore,
    // operator key commands, one-cycle pulses
    input wire logic runCmd,
    input wire logic holdCmd,
    input wire logic resetCmd,
    // control loop feedback
    input wire logic [DW-1:0] measuredTemperature,
    // register port
    input wire logic [AW-1:0] regAddr,
    input wire logic [DW-1:0] regWdata,
    input wire logic regWr,
    input wire logic regRd,
    output logic [DW-1:0] regRdata,
    // control loop drive
    output logic [DW-1:0] workingSetpoint,
    output logic heatCoolEnable,
    output logic powerLimitActive,
    output logic [DW-1:0] softstartPowerLimit,
    // indicators and state
    output logic runLamp,
    output logic alternateSetpointLamp,
    output ptp_pkg::ptp_state_e timerState
);

    // ************************************************************
    // register file
    // ************************************************************
    ptp_pkg::ptp_ctrl_s ctrl_ff; // mode, end action, servo, flags
    logic [DW-1:0] priSp_ff; // primary_setpoint
    logic [DW-1:0] altSp_ff; // alternate_setpoint
    logic [DW-1:0] dur_ff; // dwell, delay or soft start length
    logic [DW-1:0] band_ff; // dwell_start_band
    logic [DW-1:0] ssLim_ff; // softstart_power_limit
    logic [DW-1:0] ssRel_ff; // softstart_release_temp
    logic [DW-1:0] dRate_ff; // dwell-mode setpoint ramp rate
    logic [DW-1:0] segTgt [`PTP_PAIRS]; // segment_target_setpoint
    logic [DW-1:0] segRate [`PTP_PAIRS]; // ramp rate, zero is off
    logic [DW-1:0] segDwell [`PTP_PAIRS]; // dwell length in ticks
    logic [DW-1:0] rdata_ff;

    // write decode
    wire logic isSeg = regAddr[`PTP_SEG_BIT];
    wire logic wrCtrl = regWr && regAddr == `PTP_A_CTRL;
    wire logic wrState = regWr && regAddr == `PTP_A_STATE;

    // plain setting registers
    always_ff @(posedge clock) begin
        if (rst) begin
            ctrl_ff <= ptp_pkg::ptp_ctrl_s'(`PTP_CTRL_RST);
            priSp_ff <= `PTP_DATA_RST;
            altSp_ff <= `PTP_DATA_RST;
            dur_ff <= `PTP_DATA_RST;
            band_ff <= `PTP_DATA_RST;
            ssLim_ff <= `PTP_DATA_RST;
            ssRel_ff <= `PTP_DATA_RST;
            dRate_ff <= `PTP_DATA_RST;
        end else if (regWr && !isSeg) begin
            case (regAddr)
                `PTP_A_CTRL: ctrl_ff <=
                    ptp_pkg::ptp_ctrl_s'(regWdata[`PTP_CTRL_W-1:0]);
                `PTP_A_PRISP: priSp_ff <= regWdata;
                `PTP_A_ALTSP: altSp_ff <= regWdata;
                `PTP_A_DUR: dur_ff <= regWdata;
                `PTP_A_BAND: band_ff <= regWdata;
                `PTP_A_SSLIM: ssLim_ff <= regWdata;
                `PTP_A_SSREL: ssRel_ff <= regWdata;
                `PTP_A_DRATE: dRate_ff <= regWdata;
                default: ; // state and read-only words
            endcase
        end
    end

    // one group of three words per ramp and dwell pair
    for (genvar g = 0; g < `PTP_PAIRS; g++) begin : gSeg
        wire logic hit = regWr && isSeg && regAddr[3:2] == 2'(g);
        always_ff @(posedge clock) begin
            if (rst) begin
                segTgt[g] <= `PTP_DATA_RST;
                segRate[g] <= `PTP_DATA_RST;
                segDwell[g] <= `PTP_DATA_RST;
            end else if (hit) begin
                if (regAddr[1:0] == `PTP_F_TGT) begin
                    segTgt[g] <= regWdata;
                end
                if (regAddr[1:0] == `PTP_F_RATE) begin
                    segRate[g] <= regWdata;
                end
                if (regAddr[1:0] == `PTP_F_DWELL) begin
                    segDwell[g] <= regWdata;
                end
            end
        end
    end

    // ************************************************************
    // commands
    // ************************************************************
    ptp_pkg::ptp_state_e state_ff, nxt_state;
    logic pwrPend_ff; // first cycle after reset counts as power-up
    logic [DW-1:0] sp_ff, nxt_sp;
    logic [DW-1:0] count_ff, nxt_count;
    logic [3:0] seg_ff, nxt_seg;

    // state register writes act like the keys
    wire logic [1:0] wCode = regWdata[1:0];
    wire logic cReset = resetCmd ||
        (wrState && wCode == ptp_pkg::ST_RESET);
    wire logic cRun = runCmd || (wrState && wCode == ptp_pkg::ST_RUN);
    wire logic cHold = holdCmd ||
        (wrState && wCode == ptp_pkg::ST_HOLD);
    wire logic powerEvt = pwrPend_ff || powerRestore;

    // mode decode, exactly one is true
    wire logic mDwell = ctrl_ff.mode == ptp_pkg::MD_DWELL;
    wire logic mDelay = ctrl_ff.mode == ptp_pkg::MD_DELAY;
    wire logic mSoft = ctrl_ff.mode == ptp_pkg::MD_SOFT;
    wire logic mProg = ctrl_ff.mode == ptp_pkg::MD_PROG;
    wire logic eOff = ctrl_ff.endAct == ptp_pkg::EA_OFF;
    wire logic eAlt = ctrl_ff.endAct == ptp_pkg::EA_ALT;
    wire logic rebound = ctrl_ff.servo[1];
    wire logic fromPv = ctrl_ff.servo == ptp_pkg::SV_PV ||
        ctrl_ff.servo == ptp_pkg::SV_PVRB;
    wire logic isRun = state_ff == ptp_pkg::ST_RUN;

    // ************************************************************
    // segment and timing decode
    // ************************************************************
    wire logic [1:0] pair = seg_ff[2:1];
    wire logic segDwellPh = seg_ff[0]; // odd segments are dwells
    wire logic segFinal = seg_ff == `PTP_FINAL_SEG;
    wire logic [DW-1:0] pv = measuredTemperature;
    wire logic [DW-1:0] gap = pv > sp_ff ? pv - sp_ff : sp_ff - pv;
    // band gate, bypassed when set to off
    wire logic inBand = ctrl_ff.bandOff || gap <= band_ff;
    wire logic [DW-1:0] durSel = mProg ? segDwell[pair] : dur_ff;
    wire logic countDone = count_ff >= durSel; // live length

    // ramp target and rate for the present phase
    logic [DW-1:0] tgt, rate;
    always_comb begin
        tgt = priSp_ff;
        rate = '0;
        if (mProg) begin
            if (segFinal) begin
                tgt = altSp_ff; // last rate toward alternate
                rate = segRate[`PTP_PAIRS-1];
            end else if (segDwellPh) begin
                tgt = sp_ff; // dwell holds the target
            end else begin
                tgt = segTgt[pair];
                rate = segRate[pair];
            end
        end else if (mDwell && ctrl_ff.rampEn) begin
            rate = dRate_ff;
        end
    end

    // move toward target by rate, zero rate steps at once
    function automatic logic [DW-1:0] stepTo(
        input logic [DW-1:0] cur,
        input logic [DW-1:0] dst,
        input logic [DW-1:0] r
    );
        logic [DW-1:0] d;
        d = cur < dst ? dst - cur : cur - dst;
        if (r == '0 || d <= r) begin
            return dst;
        end
        return cur < dst ? cur + r : cur - r;
    endfunction

    // rate applies once per tick only
    wire logic [DW-1:0] stepped = (tick || rate == '0) ?
        stepTo(sp_ff, tgt, rate) : sp_ff;
    wire logic atTgt = sp_ff == tgt;

    // counting permission per mode
    logic canCount, finish, segAdv;
    always_comb begin
        canCount = 1'b1;
        finish = 1'b0;
        segAdv = 1'b0;
        unique case (ctrl_ff.mode)
            ptp_pkg::MD_DWELL: begin
                // ramp first, then band
                canCount = atTgt && inBand;
                finish = atTgt && countDone;
            end
            ptp_pkg::MD_DELAY: finish = countDone;
            ptp_pkg::MD_SOFT: begin
                // first of release temperature or time
                finish = countDone || pv >= ssRel_ff;
            end
            ptp_pkg::MD_PROG: begin
                canCount = segDwellPh && !segFinal && inBand;
                if (segFinal) begin
                    finish = atTgt;
                end else begin
                    segAdv = segDwellPh ? countDone : atTgt;
                    finish = segAdv && seg_ff == `PTP_LAST_SEG && !eAlt;
                end
            end
        endcase
    end

    // ************************************************************
    // state machine
    // ************************************************************
    // reset first, then run, hold, power-up, timeout
    always_comb begin
        nxt_state = state_ff;
        if (cReset) begin
            nxt_state = ptp_pkg::ST_RESET;
        end else if (cRun && !isRun) begin
            nxt_state = ptp_pkg::ST_RUN; // also from end
        end else if (cHold && isRun) begin
            nxt_state = ptp_pkg::ST_HOLD;
        end else if (powerEvt) begin
            // delay and soft start run at power-up
            if (mDelay || mSoft || (mProg && rebound)) begin
                nxt_state = ptp_pkg::ST_RUN;
            end else begin
                nxt_state = ptp_pkg::ST_RESET;
            end
        end else if (isRun && finish) begin
            nxt_state = ptp_pkg::ST_END;
        end
    end

    wire logic goRun = nxt_state == ptp_pkg::ST_RUN;
    wire logic resume = goRun && powerEvt && mProg && rebound &&
        !cRun && !cReset;
    // restart from zero, not a resume from hold
    wire logic fresh = goRun && !resume && (!isRun &&
        state_ff != ptp_pkg::ST_HOLD || (powerEvt && !mProg && !cRun));
    wire logic goReset = nxt_state == ptp_pkg::ST_RESET &&
        (state_ff != ptp_pkg::ST_RESET || powerEvt);
    wire logic goEnd = nxt_state == ptp_pkg::ST_END && isRun;

    // ************************************************************
    // setpoint, count and segment next values
    // ************************************************************
    always_comb begin
        nxt_sp = sp_ff;
        if (goReset) begin
            // reset selects primary; recovery may pick alternate
            nxt_sp = (powerEvt && ctrl_ff.spSel) ? altSp_ff : priSp_ff;
        end else if (resume) begin
            nxt_sp = fromPv ? pv : sp_ff;
        end else if (fresh) begin
            if (mProg) begin
                nxt_sp = fromPv ? pv : sp_ff;
            end else if (!(mDwell && ctrl_ff.rampEn)) begin
                nxt_sp = priSp_ff; // target setpoint
            end
        end else if (goEnd) begin
            unique case (ctrl_ff.endAct)
                ptp_pkg::EA_OFF: nxt_sp = sp_ff;
                ptp_pkg::EA_DWELL: nxt_sp = mProg ? sp_ff : priSp_ff;
                ptp_pkg::EA_ALT: nxt_sp = altSp_ff;
                ptp_pkg::EA_RESET: nxt_sp = priSp_ff;
            endcase
        end else if (isRun && goRun) begin
            nxt_sp = stepped;
        end
    end

    // elapsed ticks; a done count waits for the end step
    always_comb begin
        nxt_count = count_ff;
        if (fresh || (isRun && segAdv)) begin
            nxt_count = '0;
        end else if (isRun && goRun && tick && canCount &&
                     !countDone) begin
            nxt_count = count_ff + 1'b1;
        end
    end

    // segment index; final approach only for alternate end
    always_comb begin
        nxt_seg = seg_ff;
        if (fresh) begin
            nxt_seg = '0;
        end else if (isRun && goRun && segAdv) begin
            nxt_seg = seg_ff + 1'b1;
        end
    end

    // ************************************************************
    // output next values
    // ************************************************************
    logic nxt_heat;
    always_comb begin
        unique case (nxt_state)
            ptp_pkg::ST_RESET: nxt_heat = !eOff && !mDelay;
            ptp_pkg::ST_RUN: nxt_heat = !mDelay;
            ptp_pkg::ST_HOLD: nxt_heat = !mDelay;
            ptp_pkg::ST_END: nxt_heat = mDelay || !eOff;
        endcase
    end
    wire logic nxt_lim = nxt_state == ptp_pkg::ST_RUN && mSoft;
    logic flash_ff; // hold blink, one tick per phase
    wire logic nxt_flash = tick ? !flash_ff : flash_ff;
    // steady, flashing or dark
    wire logic nxt_runLamp = nxt_state == ptp_pkg::ST_RUN ||
        (nxt_state == ptp_pkg::ST_HOLD && nxt_flash);
    wire logic nxt_altLamp = nxt_state == ptp_pkg::ST_END && eAlt;

    // timer state registers
    always_ff @(posedge clock) begin
        if (rst) begin
            state_ff <= ptp_pkg::ST_RESET;
            pwrPend_ff <= 1'b1;
            sp_ff <= `PTP_DATA_RST;
            count_ff <= `PTP_DATA_RST;
            seg_ff <= '0;
        end else begin
            state_ff <= nxt_state;
            pwrPend_ff <= 1'b0;
            sp_ff <= nxt_sp;
            count_ff <= nxt_count;
            seg_ff <= nxt_seg;
        end
    end

    // driven outputs, registered to stay glitch free
    always_ff @(posedge clock) begin
        if (rst) begin
            heatCoolEnable <= 1'b0;
            powerLimitActive <= 1'b0;
            flash_ff <= 1'b0;
            runLamp <= 1'b0;
            alternateSetpointLamp <= 1'b0;
        end else begin
            heatCoolEnable <= nxt_heat;
            powerLimitActive <= nxt_lim;
            flash_ff <= nxt_flash;
            runLamp <= nxt_runLamp;
            alternateSetpointLamp <= nxt_altLamp;
        end
    end

    // ************************************************************
    // read port, data in the cycle after the strobe
    // ************************************************************
    logic [DW-1:0] rdMux;
    always_comb begin
        rdMux = '0; // unmapped words read zero
        if (isSeg) begin
            unique case (regAddr[1:0])
                `PTP_F_TGT: rdMux = segTgt[regAddr[3:2]];
                `PTP_F_RATE: rdMux = segRate[regAddr[3:2]];
                `PTP_F_DWELL: rdMux = segDwell[regAddr[3:2]];
                default: rdMux = '0;
            endcase
        end else begin
            case (regAddr)
                `PTP_A_CTRL: rdMux = DW'(ctrl_ff);
                `PTP_A_STATE: rdMux = DW'(state_ff);
                `PTP_A_PRISP: rdMux = priSp_ff;
                `PTP_A_ALTSP: rdMux = altSp_ff;
                `PTP_A_DUR: rdMux = dur_ff;
                `PTP_A_BAND: rdMux = band_ff;
                `PTP_A_SSLIM: rdMux = ssLim_ff;
                `PTP_A_SSREL: rdMux = ssRel_ff;
                `PTP_A_DRATE: rdMux = dRate_ff;
                `PTP_A_ELAPSED: rdMux = count_ff;
                `PTP_A_WSP: rdMux = sp_ff;
                default: rdMux = '0;
            endcase
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            rdata_ff <= `PTP_DATA_RST;
        end else if (regRd) begin
            rdata_ff <= rdMux;
        end
    end

    assign regRdata = rdata_ff;
    assign workingSetpoint = sp_ff;
    assign timerState = state_ff;
    // full power unless the soft start clamp is active
    assign softstartPowerLimit = powerLimitActive ? ssLim_ff :
        `PTP_LIMIT_FULL;

    // ************************************************************
    // checks
    // ************************************************************
    default clocking cb @(posedge clock); endclocking
    default disable iff (rst);

    sequence endEntry;
        state_ff != ptp_pkg::ST_END ##1 state_ff == ptp_pkg::ST_END;
    endsequence
    sequence dwellWait;
        isRun && goRun && mDwell && !ctrl_ff.bandOff && !inBand;
    endsequence

    resetWins_a: assert property (cReset |=>
        state_ff == ptp_pkg::ST_RESET)
        else $error("reset command did not win");
    endRestart_a: assert property (
        state_ff == ptp_pkg::ST_END && cRun && !cReset |=>
        isRun && count_ff == '0)
        else $error("run from end did not restart");
    stateWrite_a: assert property (
        wrState && wCode == ptp_pkg::ST_RUN && !resetCmd &&
        state_ff == ptp_pkg::ST_RESET |=> isRun)
        else $error("state write did not start the timer");
    bandGate_a: assert property (dwellWait |=>
        $stable(count_ff))
        else $error("dwell counted outside band");
    rampGate_a: assert property (
        isRun && goRun && mDwell && !atTgt |=> $stable(count_ff))
        else $error("dwell counted during ramp");
    delayOff_a: assert property (
        isRun && mDelay |-> !heatCoolEnable)
        else $error("delayed timer drove outputs early");
    softLimit_a: assert property (
        isRun && mSoft |-> powerLimitActive &&
        softstartPowerLimit == ssLim_ff)
        else $error("soft start limit missing");
    endOff_a: assert property (
        (eOff && !mDelay) ##0 endEntry ##0 (eOff && !mDelay) |->
        !heatCoolEnable)
        else $error("end action off left outputs on");
    altLamp_a: assert property (
        endEntry ##0 eAlt |-> alternateSetpointLamp && !runLamp)
        else $error("alternate lamp wrong at end");
    runLamp_a: assert property (isRun |-> runLamp)
        else $error("run lamp not steady in run");
    resetSp_a: assert property (
        isRun && cReset && !powerEvt |=> sp_ff == $past(priSp_ff))
        else $error("reset did not select primary setpoint");
    powerUp_a: assert property (
        powerEvt && mDelay && !cReset && !cRun && !cHold |=>
        isRun && count_ff == '0)
        else $error("delayed timer missed power-up start");

endmodule

// ==== tb/ptp_loop_model.sv ====
// Purpose: heater and sensor stand-in for the timer block
// Assumes: one unit of travel per tick toward the setpoint
// Notes: temperature holds still while outputs are off
`timescale 1ns/1ps
module ptp_loop_model (
    // clock and timebase
    input wire logic clock,
    input wire logic rst,
    input wire logic tick,
    // drive from the block
    input wire logic heatCoolEnable,
    input wire logic [15:0] workingSetpoint,
    // sensed temperature back to the block
    output logic [15:0] measuredTemperature
);
    // slow lag so band gating is visible
    always @(posedge clock) begin
        if (rst) begin
            measuredTemperature <= 16'h0000;
        end else if (tick && heatCoolEnable) begin
            if (measuredTemperature < workingSetpoint) begin
                measuredTemperature <= measuredTemperature + 16'h0001;
            end else if (measuredTemperature > workingSetpoint) begin
                measuredTemperature <= measuredTemperature - 16'h0001;
            end
        end
    end
endmodule

// ==== tb/tb_process_timer_programmer.sv ====
// Purpose: self-checking bench of the timer block
// Assumes: loop model closes the temperature path
// Notes: tick every fourth cycle keeps runs short
`timescale 1ns/1ps
`include "ptp_cfg.svh"
module tb_process_timer_programmer;
    logic clock, rst, tick, runCmd, holdCmd, resetCmd, regWr, regRd, pwr;
    logic [4:0] regAddr;
    logic [15:0] regWdata, regRdata, temp, wsp, lim;
    logic heat, limAct, runLamp, altLamp;
    ptp_pkg::ptp_state_e st;
    int error_cnt = 0, checks = 0, cyc = 0;
    // supply event pulsed by cmd code 3
    ptp_timer dut (.clock(clock), .rst(rst), .tick(tick),
        .powerRestore(pwr), .runCmd(runCmd), .holdCmd(holdCmd),
        .resetCmd(resetCmd), .measuredTemperature(temp),
        .regAddr(regAddr), .regWdata(regWdata), .regWr(regWr),
        .regRd(regRd), .regRdata(regRdata), .workingSetpoint(wsp),
        .heatCoolEnable(heat), .powerLimitActive(limAct),
        .softstartPowerLimit(lim), .runLamp(runLamp),
        .alternateSetpointLamp(altLamp), .timerState(st));
    ptp_loop_model loopModel (.clock(clock), .rst(rst), .tick(tick),
        .heatCoolEnable(heat), .workingSetpoint(wsp),
        .measuredTemperature(temp));
    initial begin
        clock = 1'b0;
        forever #25 clock = ~clock;
    end
    // timebase strobe and hang guard
    always @(posedge clock) begin
        cyc++;
        tick <= (cyc % 4 == 0);
        if (cyc == 20000) begin
            error_cnt++;
            give_verdict();
        end
    end
    // ************************************************************
    // shared tasks
    // ************************************************************
    task automatic give_verdict;
        $display("checks %0d mismatches %0d", checks, error_cnt);
        if (error_cnt == 0 && checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("unexpected at %0t: got %h want %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [4:0] a, input logic [15:0] d);
        @(posedge clock);
        {regWr, regAddr, regWdata} <= {1'b1, a, d};
        @(posedge clock);
        regWr <= 1'b0;
    endtask
    task automatic rd(input logic [4:0] a, input logic [15:0] e);
        @(posedge clock);
        {regRd, regAddr} <= {1'b1, a};
        @(posedge clock);
        regRd <= 1'b0;
        #1;
        chk(regRdata, e);
    endtask
    // k: 0 run, 1 hold, 2 reset, 3 power restored
    task automatic cmd(input logic [1:0] k);
        @(posedge clock);
        {runCmd, holdCmd, resetCmd} <= 3'(3'b100 >> k);
        pwr <= (k == 2'h3);
        @(posedge clock);
        {runCmd, holdCmd, resetCmd} <= 3'b000;
        pwr <= 1'b0;
        #1;
    endtask
    task automatic waitEnd;
        for (int i = 0; i < 2000 && st !== ptp_pkg::ST_END; i++) begin
            @(posedge clock);
        end
        #1;
        chk({14'h0, st}, {14'h0, ptp_pkg::ST_END});
    endtask
    // ************************************************************
    // scenarios
    // ************************************************************
    task automatic bandTest;
        wr(`PTP_A_PRISP, 16'h0028);
        wr(`PTP_A_BAND, 16'h0002);
        wr(`PTP_A_DUR, 16'h0002);
        wr(`PTP_A_CTRL, 16'h0084);
        wr(`PTP_A_DRATE, 16'h0004);
        cmd(2'h0);
        chk({15'h0, heat}, 16'h0001);
        repeat (12) @(posedge clock);
        rd(`PTP_A_ELAPSED, 16'h0000);
        wr(`PTP_A_DUR, 16'h0001);
        waitEnd();
        chk(wsp, 16'h0028);
        cmd(2'h2);
        chk(wsp, 16'h0028);
        $display("band gated dwell finished");
    endtask
    task automatic altTest;
        wr(`PTP_A_ALTSP, 16'h003C);
        wr(`PTP_A_CTRL, 16'h0048);
        cmd(2'h0);
        waitEnd();
        chk(wsp, 16'h003C);
        chk({14'h0, altLamp, runLamp}, 16'h0002);
        cmd(2'h0);
        chk({14'h0, st}, {14'h0, ptp_pkg::ST_RUN});
        cmd(2'h2);
        chk(wsp, 16'h0028);
        $display("alternate end finished");
    endtask
    task automatic offTest;
        logic lamp;
        wr(`PTP_A_CTRL, 16'h0040);
        wr(`PTP_A_DUR, 16'h0010);
        wr(`PTP_A_STATE, 16'h0001);
        rd(`PTP_A_STATE, 16'h0001);
        wr(`PTP_A_STATE, 16'h0003);
        rd(`PTP_A_STATE, 16'h0003);
        lamp = runLamp;
        repeat (4) @(posedge clock);
        #1;
        chk({15'h0, runLamp}, {15'h0, !lamp});
        wr(`PTP_A_STATE, 16'h0000);
        rd(`PTP_A_STATE, 16'h0000);
        cmd(2'h0);
        waitEnd();
        chk({15'h0, heat}, 16'h0000);
        cmd(2'h2);
        chk({15'h0, heat}, 16'h0000);
        $display("off end finished");
    endtask
    task automatic progTest;
        wr(`PTP_A_CTRL, 16'h0047);
        wr(`PTP_A_PRISP, 16'h0030);
        for (int p = 0; p < 4; p++) begin
            wr(5'(5'h10 + 4 * p), 16'h0010);
        end
        wr(5'h12, 16'h0002);
        cmd(2'h0);
        chk(wsp, 16'h0028);
        waitEnd();
        chk(wsp, 16'h0010);
        $display("programmer finished");
    endtask
    task automatic delaySoftTest;
        wr(`PTP_A_CTRL, 16'h0001);
        cmd(2'h3);
        chk({14'h0, st}, {14'h0, ptp_pkg::ST_RUN});
        chk({15'h0, heat}, 16'h0000);
        waitEnd();
        chk({15'h0, heat}, 16'h0001);
        chk(wsp, 16'h0030);
        wr(`PTP_A_SSLIM, 16'h0032);
        wr(`PTP_A_SSREL, 16'h0064);
        wr(`PTP_A_CTRL, 16'h0002);
        cmd(2'h3);
        chk(lim, 16'h0032);
        waitEnd();
        chk(lim, 16'hFFFF);
        $display("delayed and soft start finished");
    endtask
    initial begin
        {pwr, runCmd, holdCmd, resetCmd, regWr, regRd} = '0;
        {regAddr, regWdata} = '0;
        rst = 1'b1;
        repeat (2) @(posedge clock);
        rst <= 1'b0;
        rd(`PTP_A_CTRL, 16'h0004);
        chk(lim, 16'hFFFF);
        bandTest();
        altTest();
        offTest();
        progTest();
        delaySoftTest();
        give_verdict();
    end
endmodule
